// ---- shared/hostport_if.sv ----
// pin bundle joining the host end and the device end of the register port
`default_nettype none
interface hostport_if;
	logic if_sel; // high selects the i2c port type
	logic cs_n; // spi chip select, active low
	logic sclk; // shared serial clock, driven by the host
	logic host_dat_out; // host value for the shared data pin
	logic host_dat_oe; // host drives the shared data pin
	logic dev_dat_out; // device value for the shared data pin
	logic dev_dat_oe; // device pulls the shared data pin
	logic dev_sdo_out; // device spi serial output
	logic dev_sdo_oe; // device drives the serial output
	logic dat_line; // resolved shared data pin, pulled up
	logic sdo_line; // resolved serial output pin, pulled up
	// any driven low wins, otherwise the pull-up or a driven high shows
	assign dat_line = ~((host_dat_oe & ~host_dat_out) | (dev_dat_oe & ~dev_dat_out));
	assign sdo_line = dev_sdo_oe ? dev_sdo_out : 1'b1;
	modport device (
		input if_sel, cs_n, sclk, dat_line,
		output dev_dat_out, dev_dat_oe, dev_sdo_out, dev_sdo_oe
	);
	modport host (
		output if_sel, cs_n, sclk, host_dat_out, host_dat_oe,
		input dat_line, sdo_line
	);
endinterface
`default_nettype wire

// ---- shared/hostport_pkg.sv ----
// constants and types shared by both ends of the serial register port
`default_nettype none
package hostport_pkg;
	localparam int REG_AW = 5; // register address width
	localparam int DAT_W = 8; // register data width
	localparam int SLV_AW = 7; // bus slave address width
	localparam logic [4:0] REG_LAST = 5'h1F; // highest register address
	localparam logic [6:0] SLV_ADDR_DEF = 7'h00; // default slave address
	localparam logic [4:0] SPI_BITS = 5'h10; // header byte plus data byte
	localparam logic [4:0] SPI_HDR_LAST = 5'h07; // count at last header bit
	localparam logic [4:0] SPI_HDR_BITS = 5'h08; // count once header is in
	localparam int HDR_RW = 7; // read/write bit in header
	localparam int HDR_AD_MSB = 6; // register address field in header
	localparam int HDR_AD_LSB = 2;
	localparam int SEL_AD_MSB = 4; // register field of the i2c pointer byte
	localparam logic [3:0] I2C_ACK_CNT = 4'h8; // bit count at the ninth clock
	localparam int I2C_SLOT = 9; // bits per byte including acknowledge
	localparam int I2C_WR_LEN = 27; // address, pointer, data
	localparam int I2C_RD_LEN = 36; // address, pointer, address, data
	localparam int I2C_SR_AT = 18; // repeated start before this bit
	localparam int SEQ_W = 36; // master bit sequence width
	localparam int CLK_PERIOD_NS = 10; // system clock period
	localparam int LINK_PERIOD_NS = 125; // nominal serial clock half period
	localparam int LINK_QTR_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS); // rounds down
	localparam int SWITCH_MAX_NS = 8000; // port type switch limit
	localparam int SYNC_LAT_CYC = 4; // synchroniser and decode latency
	localparam int SWITCH_MAX_CYC = SWITCH_MAX_NS / CLK_PERIOD_NS - SYNC_LAT_CYC;
	localparam int SW_CNT_W = 10; // width of switch counters
	localparam int FIFO_DEPTH = 2; // write buffer entries
	localparam int WORD_W = REG_AW + DAT_W; // buffered word: address and data
	// slave side protocol states
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_ADDR = 3'h1,
		S_PTR = 3'h3,
		S_DATA = 3'h2,
		S_RDA = 3'h6,
		S_READ = 3'h7,
		S_WAIT = 3'h5
	} slave_state_type;
	// master side sequencer states
	typedef enum logic [2:0] {
		M_IDLE = 3'h0,
		M_START = 3'h1,
		M_BITS = 3'h3,
		M_STOP = 3'h2,
		M_CSUP = 3'h6,
		M_DONE = 3'h7
	} master_state_type;
endpackage
`default_nettype wire

// ---- src/regport_device.sv ----
// device end: spi or i2c slave giving byte access to a 32-entry register space
`default_nettype none
module regport_device
	#(
		parameter logic [hostport_pkg::SLV_AW-1:0] OWN_ADDR = hostport_pkg::SLV_ADDR_DEF,
		parameter int DEPTH = hostport_pkg::FIFO_DEPTH
	)
	(
		input wire logic clk_in,
		input wire logic rst_in,
		hostport_if.device lnk,
		output logic wr_valid_out,
		input wire logic wr_ready_in,
		output logic [hostport_pkg::REG_AW-1:0] wr_addr_out,
		output logic [hostport_pkg::DAT_W-1:0] wr_data_out,
		output logic [hostport_pkg::REG_AW-1:0] rd_addr_out,
		input wire logic [hostport_pkg::DAT_W-1:0] rd_data_in,
		output logic i2c_mode_out,
		output logic busy_out
	);
	import hostport_pkg::*;

	// next pointer, wrapping back to where the burst began
	function automatic logic [REG_AW-1:0] next_ptr(input logic [REG_AW-1:0] p,
		input logic [REG_AW-1:0] s);
		next_ptr = (p == REG_LAST) ? s : REG_AW'(p + 5'h01);
	endfunction

	logic [2:0] pin_s1; // first stage: cs_n, sclk, data
	logic [2:0] pin_s2; // second stage, safe to decode
	logic [2:0] pin_s3; // delayed copy for edge finding
	logic sel_s1; // select strap synchroniser
	logic sel_s2;
	logic mode_r; // 1 = i2c port active
	logic [SW_CNT_W-1:0] sw_cnt_r; // cycles a switch has waited
	logic busy; // either engine inside a transfer
	logic cs_s, scl_s, dat_s; // synchronised pin levels
	logic cs_fall, cs_rise, scl_rise, scl_fall, dat_rise, dat_fall;
	// spi engine state
	logic spi_act_r; // frame open
	logic spi_pol_r; // 1 = sample on rising edge
	logic [4:0] spi_cnt_r; // bits sampled so far
	logic [DAT_W-1:0] spi_sh_r; // input shifter
	logic [DAT_W-1:0] spi_tx_r; // output shifter
	logic spi_rw_r; // 1 = read frame
	logic [REG_AW-1:0] spi_addr_r; // decoded register address
	logic spi_push_r; // one-cycle write request
	logic sdo_r, sdo_oe_r;
	logic spi_smp, spi_lau;
	logic [DAT_W-1:0] spi_hdr; // header as it completes
	// i2c engine state
	slave_state_type i_st_r;
	logic [3:0] i_cnt_r; // bit within the nine-bit slot
	logic [DAT_W-1:0] i_sh_r; // received byte
	logic [DAT_W-1:0] i_tx_r; // byte being sent
	logic [REG_AW-1:0] i_ptr_r; // register pointer
	logic [REG_AW-1:0] i_beg_r; // pointer where the burst began
	logic i_push_r; // one-cycle write request
	logic [REG_AW-1:0] i_wad_r; // register of the data byte just acknowledged
	logic sda_oe_r; // pull the data pin low
	logic i_act, i_hit;
	// write buffer
	logic [WORD_W-1:0] mem_r [DEPTH];
	logic [WORD_W-1:0] mem_nxt [DEPTH];
	logic [DEPTH-1:0] val_r, val_nxt;
	logic push, pop, fifo_ready, placed;
	logic [WORD_W-1:0] push_word;

	// all link pins are foreign to clk_in, so two flops before use
	always_ff @(posedge clk_in)
	begin
		pin_s1 <= {lnk.cs_n, lnk.sclk, lnk.dat_line};
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
		sel_s1 <= lnk.if_sel;
		sel_s2 <= sel_s1;
	end

	assign cs_s = pin_s2[2];
	assign scl_s = pin_s2[1];
	assign dat_s = pin_s2[0];
	assign cs_fall = pin_s3[2] & ~cs_s;
	assign cs_rise = ~pin_s3[2] & cs_s;
	assign scl_rise = ~pin_s3[1] & scl_s;
	assign scl_fall = pin_s3[1] & ~scl_s;
	assign dat_rise = ~pin_s3[0] & dat_s;
	assign dat_fall = pin_s3[0] & ~dat_s;
	assign busy = spi_act_r | (i_st_r != S_IDLE);

	// port type follows the strap once idle; a strap moved mid-transfer
	// still switches, aborting the transfer, so the limit always holds
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			mode_r <= 1'b0;
			sw_cnt_r <= '0;
		end
		else if (sel_s2 == mode_r)
			sw_cnt_r <= '0;
		else if (!busy || sw_cnt_r == SW_CNT_W'(SWITCH_MAX_CYC))
		begin
			mode_r <= sel_s2;
			sw_cnt_r <= '0;
		end
		else
			sw_cnt_r <= SW_CNT_W'(sw_cnt_r + 10'h001);
	end

	// sampling and launching edges chosen by the stored polarity
	assign spi_smp = spi_act_r & (spi_pol_r ? scl_rise : scl_fall);
	assign spi_lau = spi_act_r & (spi_pol_r ? scl_fall : scl_rise);
	assign spi_hdr = {spi_sh_r[DAT_W-2:0], dat_s};

	// spi slave: never drives the clock, only answers the master
	always_ff @(posedge clk_in)
	begin
		if (rst_in || mode_r)
		begin
			spi_act_r <= 1'b0;
			spi_pol_r <= 1'b0;
			spi_cnt_r <= '0;
			spi_rw_r <= 1'b0;
			spi_push_r <= 1'b0;
			sdo_oe_r <= 1'b0;
			sdo_r <= 1'b0;
		end
		else
		begin
			spi_push_r <= 1'b0;
			if (cs_fall)
			begin
				spi_act_r <= 1'b1;
				spi_pol_r <= scl_s;
				spi_cnt_r <= '0;
			end
			else if (cs_rise)
			begin
				// frame ends here; a short or read frame writes nothing
				spi_act_r <= 1'b0;
				sdo_oe_r <= 1'b0;
				spi_push_r <= spi_act_r & ~spi_rw_r & (spi_cnt_r == SPI_BITS)
					& fifo_ready;
			end
			else if (spi_smp && spi_cnt_r != SPI_BITS)
			begin
				spi_sh_r <= spi_hdr;
				spi_cnt_r <= 5'(spi_cnt_r + 5'h01);
				if (spi_cnt_r == SPI_HDR_LAST)
				begin
					// reserved bits at the bottom of the header are ignored
					spi_rw_r <= spi_hdr[HDR_RW];
					spi_addr_r <= spi_hdr[HDR_AD_MSB:HDR_AD_LSB];
				end
			end
			else if (spi_lau && spi_rw_r && spi_cnt_r >= SPI_HDR_BITS)
			begin
				// first launch after the header loads the addressed byte
				sdo_oe_r <= 1'b1;
				if (spi_cnt_r == SPI_HDR_BITS)
				begin
					sdo_r <= rd_data_in[DAT_W-1];
					spi_tx_r <= {rd_data_in[DAT_W-2:0], 1'b0};
				end
				else
				begin
					sdo_r <= spi_tx_r[DAT_W-1];
					spi_tx_r <= {spi_tx_r[DAT_W-2:0], 1'b0};
				end
			end
		end
	end

	assign i_act = mode_r & (i_st_r != S_IDLE);
	// only the strapped address is answered; reserved codes that differ
	// from it (general call, start byte, high-speed code) get no ack
	assign i_hit = (i_sh_r[DAT_W-1:1] == OWN_ADDR);

	// i2c slave: start/stop win over bit handling, ack on the ninth clock
	always_ff @(posedge clk_in)
	begin
		if (rst_in || !mode_r)
		begin
			i_st_r <= S_IDLE;
			i_cnt_r <= '0;
			sda_oe_r <= 1'b0;
			i_push_r <= 1'b0;
			i_ptr_r <= '0;
			i_beg_r <= '0;
		end
		else
		begin
			i_push_r <= 1'b0;
			if (scl_s && dat_fall)
			begin
				i_st_r <= S_ADDR;
				i_cnt_r <= '0;
				sda_oe_r <= 1'b0;
			end
			else if (scl_s && dat_rise)
			begin
				i_st_r <= S_IDLE;
				sda_oe_r <= 1'b0;
			end
			else if (scl_rise && i_act)
			begin
				if (i_cnt_r != I2C_ACK_CNT)
				begin
					i_sh_r <= {i_sh_r[DAT_W-2:0], dat_s};
					i_cnt_r <= 4'(i_cnt_r + 4'h1);
				end
				else
				begin
					i_cnt_r <= '0;
					if (i_st_r == S_RDA)
						i_st_r <= S_READ;
					else if (i_st_r == S_READ && dat_s)
						i_st_r <= S_WAIT;
					else if (i_st_r == S_READ)
						i_ptr_r <= next_ptr(i_ptr_r, i_beg_r);
				end
			end
			else if (scl_fall && i_act)
			begin
				if (i_cnt_r == I2C_ACK_CNT)
				begin
					// ninth clock low phase: pull low to acknowledge
					sda_oe_r <= 1'b0;
					case (i_st_r)
						S_ADDR:
						begin
							sda_oe_r <= i_hit;
							if (!i_hit)
								i_st_r <= S_WAIT;
							else if (i_sh_r[0])
								i_st_r <= S_RDA;
							else
								i_st_r <= S_PTR;
						end
						S_PTR:
						begin
							sda_oe_r <= 1'b1;
							i_ptr_r <= i_sh_r[SEL_AD_MSB:0];
							i_beg_r <= i_sh_r[SEL_AD_MSB:0];
							i_st_r <= S_DATA;
						end
						S_DATA:
						begin
							// a full buffer is refused with a missing ack
							sda_oe_r <= fifo_ready;
							i_push_r <= fifo_ready;
							i_wad_r <= i_ptr_r;
							if (fifo_ready)
								i_ptr_r <= next_ptr(i_ptr_r, i_beg_r);
							else
								i_st_r <= S_WAIT;
						end
						default:
							sda_oe_r <= 1'b0;
					endcase
				end
				else if (i_cnt_r == 4'h0)
				begin
					// release the ack; in a read send the first bit of the byte
					sda_oe_r <= (i_st_r == S_READ) & ~rd_data_in[DAT_W-1];
					i_tx_r <= {rd_data_in[DAT_W-2:0], 1'b0};
				end
				else
				begin
					sda_oe_r <= (i_st_r == S_READ) & ~i_tx_r[DAT_W-1];
					i_tx_r <= {i_tx_r[DAT_W-2:0], 1'b0};
				end
			end
		end
	end

	// one register address port serves both engines
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			rd_addr_out <= '0;
		else
			rd_addr_out <= mode_r ? i_ptr_r : spi_addr_r;
		busy_out <= rst_in ? 1'b0 : busy;
	end

	assign push = spi_push_r | i_push_r;
	// the pointer has already moved on when the push lands, so use the saved one
	assign push_word = spi_push_r ? {spi_addr_r, spi_sh_r} : {i_wad_r, i_sh_r};
	assign pop = val_r[0] & wr_ready_in;
	// full is judged before a pop, which costs a little throughput
	assign fifo_ready = ~val_r[DEPTH-1];

	// two-entry shift buffer: entry 0 is always the head
	always_comb
	begin
		placed = 1'b0;
		mem_nxt = mem_r;
		val_nxt = val_r;
		if (pop)
		begin
			for (int i = 0; i < DEPTH - 1; i++)
			begin
				mem_nxt[i] = mem_r[i + 1];
				val_nxt[i] = val_r[i + 1];
			end
			val_nxt[DEPTH-1] = 1'b0;
		end
		for (int i = 0; i < DEPTH; i++)
		begin
			if (push && !val_nxt[i] && !placed)
			begin
				mem_nxt[i] = push_word;
				val_nxt[i] = 1'b1;
				placed = 1'b1;
			end
		end
	end

	// buffer storage
	always_ff @(posedge clk_in)
	begin
		val_r <= rst_in ? '0 : val_nxt;
		mem_r <= mem_nxt;
	end

	assign wr_valid_out = val_r[0];
	assign wr_addr_out = mem_r[0][WORD_W-1:DAT_W];
	assign wr_data_out = mem_r[0][DAT_W-1:0];
	assign i2c_mode_out = mode_r;
	assign lnk.dev_dat_out = 1'b0; // open drain: only ever pulls low
	assign lnk.dev_dat_oe = sda_oe_r;
	assign lnk.dev_sdo_out = sdo_r;
	assign lnk.dev_sdo_oe = sdo_oe_r;
endmodule
`default_nettype wire

// ---- src/regport_host.sv ----
// host end: spi or i2c master issuing single-register reads and writes
`default_nettype none
module regport_host
	#(
		parameter logic [hostport_pkg::SLV_AW-1:0] DEV_ADDR = hostport_pkg::SLV_ADDR_DEF,
		parameter int QTR_CYC = hostport_pkg::LINK_QTR_CYC
	)
	(
		input wire logic clk_in,
		input wire logic rst_in,
		hostport_if.host lnk,
		input wire logic sel_i2c_in,
		input wire logic cmd_valid_in,
		output logic cmd_ready_out,
		input wire logic cmd_write_in,
		input wire logic [hostport_pkg::REG_AW-1:0] cmd_addr_in,
		input wire logic [hostport_pkg::DAT_W-1:0] cmd_data_in,
		output logic rsp_valid_out,
		output logic [hostport_pkg::DAT_W-1:0] rsp_data_out,
		output logic rsp_ack_out
	);
	import hostport_pkg::*;

	master_state_type st_r;
	logic [1:0] q_r; // quarter of the current bit or condition
	logic [7:0] tk_r; // cycles within a quarter
	logic tick;
	logic sel_r; // port type in use, changed only when idle
	logic [SW_CNT_W-1:0] sw_r; // settle time after a port type change
	logic [SEQ_W-1:0] seq_r; // bits still to send, msb first
	logic [5:0] n_r; // bits sent
	logic [5:0] len_r; // bits in the frame
	logic [5:0] sr_r; // bit that a repeated start precedes
	logic [8:0] rx_r; // sampled bits
	logic ok_r; // every device acknowledge seen
	logic clk_r, cs_r, dat_r, oe_r;
	logic [1:0] ln_s1, ln_s2; // synchronisers for data and sdo lines
	logic smp, ack_slot;
	logic [SEQ_W-1:0] spi_seq, wr_seq, rd_seq;

	always_ff @(posedge clk_in)
	begin
		ln_s1 <= {lnk.dat_line, lnk.sdo_line};
		ln_s2 <= ln_s1;
	end

	assign tick = (tk_r == 8'(QTR_CYC - 1));
	assign smp = sel_r ? ln_s2[1] : ln_s2[0];
	assign ack_slot = (n_r % 6'(I2C_SLOT) == 6'(I2C_SLOT - 1)) && (n_r != 6'(I2C_RD_LEN - 1));
	// frames, left aligned; reserved fields go out as zero
	assign spi_seq = {~cmd_write_in, cmd_addr_in, 2'h0, cmd_data_in, 20'h00000};
	assign wr_seq = {DEV_ADDR, 1'b0, 1'b1, 3'h0, cmd_addr_in, 1'b1, cmd_data_in, 1'b1,
		9'h000};
	assign rd_seq = {DEV_ADDR, 1'b0, 1'b1, 3'h0, cmd_addr_in, 1'b1, DEV_ADDR, 1'b1, 1'b1,
		8'hFF, 1'b1};

	// sequencer; the host alone starts frames and makes every edge
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			st_r <= M_IDLE;
			q_r <= '0;
			tk_r <= '0;
			sel_r <= 1'b0;
			sw_r <= '0;
			clk_r <= 1'b0;
			cs_r <= 1'b1;
			dat_r <= 1'b1;
			oe_r <= 1'b0;
			cmd_ready_out <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_data_out <= '0;
			rsp_ack_out <= 1'b0;
		end
		else
		begin
			rsp_valid_out <= 1'b0;
			tk_r <= tick ? 8'h00 : 8'(tk_r + 8'h01);
			if (tick)
				q_r <= 2'(q_r + 2'h1);
			case (st_r)
				M_IDLE:
				begin
					clk_r <= sel_r;
					dat_r <= 1'b1;
					oe_r <= ~sel_r;
					// a pending port type change holds commands off until it has settled
					cmd_ready_out <= (sw_r == '0) && (sel_r == sel_i2c_in)
						&& !(cmd_valid_in && cmd_ready_out);
					if (cmd_valid_in && cmd_ready_out)
					begin
						seq_r <= sel_r ? (cmd_write_in ? wr_seq : rd_seq) : spi_seq;
						len_r <= sel_r ? (cmd_write_in ? 6'(I2C_WR_LEN) : 6'(I2C_RD_LEN))
							: 6'(SPI_BITS);
						sr_r <= (sel_r && !cmd_write_in) ? 6'(I2C_SR_AT) : 6'h3F;
						n_r <= '0;
						ok_r <= 1'b1;
						tk_r <= '0;
						q_r <= '0;
						cs_r <= sel_r;
						st_r <= sel_r ? M_START : M_BITS;
					end
					else if (sel_r != sel_i2c_in)
					begin
						sel_r <= sel_i2c_in;
						sw_r <= SW_CNT_W'(SWITCH_MAX_CYC);
					end
					else if (sw_r != '0)
						sw_r <= SW_CNT_W'(sw_r - 10'h001);
				end
				M_START:
					if (tick)
					begin
						// release, raise clock, pull data low while high
						case (q_r)
							2'h0: oe_r <= 1'b0;
							2'h1: clk_r <= 1'b1;
							2'h2:
							begin
								// data must be driven low here, idle leaves it high
								dat_r <= 1'b0;
								oe_r <= 1'b1;
							end
							default:
							begin
								clk_r <= 1'b0;
								st_r <= M_BITS;
							end
						endcase
					end
				M_BITS:
					if (tick)
					begin
						// data moves only in the first quarter, clock low
						case (q_r)
							2'h0:
							begin
								dat_r <= seq_r[SEQ_W-1];
								oe_r <= sel_r ? ~seq_r[SEQ_W-1] : 1'b1;
							end
							2'h1: clk_r <= 1'b1;
							2'h2:
							begin
								rx_r <= {rx_r[7:0], smp};
								if (sel_r && ack_slot)
									ok_r <= ok_r & ~smp;
							end
							default:
							begin
								clk_r <= 1'b0;
								seq_r <= {seq_r[SEQ_W-2:0], 1'b1};
								n_r <= 6'(n_r + 6'h01);
								if (n_r == 6'(len_r - 6'h01))
									st_r <= sel_r ? M_STOP : M_CSUP;
								else if (n_r == 6'(sr_r - 6'h01))
									st_r <= M_START;
							end
						endcase
					end
				M_STOP:
					if (tick)
					begin
						// low data, raise clock, release data while high
						case (q_r)
							2'h0:
							begin
								dat_r <= 1'b0;
								oe_r <= 1'b1;
							end
							2'h1: clk_r <= 1'b1;
							2'h2: oe_r <= 1'b0;
							default: st_r <= M_DONE;
						endcase
					end
				M_CSUP:
					if (tick)
					begin
						// deselect a quarter after the last edge
						cs_r <= 1'b1;
						st_r <= M_DONE;
					end
				M_DONE:
				begin
					rsp_valid_out <= 1'b1;
					rsp_data_out <= sel_r ? rx_r[8:1] : rx_r[7:0];
					rsp_ack_out <= ok_r;
					st_r <= M_IDLE;
				end
				default: st_r <= M_IDLE;
			endcase
		end
	end

	assign lnk.if_sel = sel_r;
	assign lnk.cs_n = cs_r;
	assign lnk.sclk = clk_r;
	assign lnk.host_dat_out = dat_r;
	assign lnk.host_dat_oe = oe_r;
endmodule
`default_nettype wire

// ---- test/regport_properties.sv ----
// concurrent checks on the pins joining the host end and the device end
`default_nettype none
module regport_checker (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic if_sel,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic dev_dat_out,
	input wire logic dev_dat_oe,
	input wire logic dev_sdo_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] quiet_r; // cycles with select high, saturating
	logic [9:0] spi_age_r; // cycles since spi was chosen, saturating
	logic [4:0] rises_r; // clock rises inside the open frame
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// counters restart on the event they measure from; quiet_r and spi_age_r saturate to avoid wrap
	always_ff @(posedge clk_in)
	begin
		quiet_r <= (rst_in || !cs_n) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hF};
		spi_age_r <= (rst_in || if_sel) ? 10'h000 : spi_age_r + {9'h000, spi_age_r != 10'h3FF};
		rises_r <= (rst_in || $fell(cs_n)) ? 5'h00 : rises_r + {4'h0, !cs_n && $rose(sclk)};
	end
	a_sdo_release_quiet: assert property (quiet_r >= 4'h8 |-> !dev_sdo_oe)
		else $error("serial output driven while deselected");
	a_sdo_spi_only: assert property (dev_sdo_oe |-> !if_sel)
		else $error("serial output driven in i2c selection");
	a_pull_i2c_only: assert property (spi_age_r >= 10'h320 |-> !dev_dat_oe)
		else $error("data pin pulled while spi selected");
	a_open_drain_low: assert property (dev_dat_oe |-> !dev_dat_out)
		else $error("data pin driven high");
	a_ack_low_phase: assert property ($changed(dev_dat_oe) |-> !sclk)
		else $error("data pin changed while clock high");
	a_frame_sixteen: assert property ($rose(cs_n) |-> rises_r == 5'h10)
		else $error("frame without sixteen clocks");
	a_clock_idle_select: assert property ($fell(cs_n) |-> !sclk ##1 !cs_n)
		else $error("select fell with clock not idle");
	a_select_steady: assert property ($changed(if_sel) |-> cs_n && !dev_dat_oe)
		else $error("port type changed during transfer");
	a_i2c_no_select: assert property (if_sel |-> cs_n)
		else $error("select low in i2c selection");
	c_spi_frame: cover property ($fell(cs_n));
	c_i2c_ack: cover property ($rose(dev_dat_oe));
	c_spi_read: cover property ($rose(dev_sdo_oe));
	c_switch: cover property ($rose(if_sel));
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench: host end and device end joined back to back
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import hostport_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic sel_i2c = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic [REG_AW-1:0] cmd_addr = 5'h00;
	logic [DAT_W-1:0] cmd_data = 8'h00;
	logic cmd_ready, rsp_valid, rsp_ack, wr_valid, i2c_mode, busy;
	logic wr_ready = 1'b1; // low stalls the register file
	logic [DAT_W-1:0] rsp_data, wr_data, rd_data;
	logic [REG_AW-1:0] wr_addr, rd_addr;
	logic [DAT_W-1:0] regs_r [32]; // register file standing behind the device
	logic busy_seen;
	int num_errors = 0;
	int total_checks = 0;
	hostport_if lnk ();
	regport_host regport_host_inst (.clk_in(clk_in), .rst_in(rst_in), .lnk(lnk),
		.sel_i2c_in(sel_i2c), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready),
		.cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data),
		.rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .rsp_ack_out(rsp_ack));
	regport_device regport_device_inst (.clk_in(clk_in), .rst_in(rst_in), .lnk(lnk),
		.wr_valid_out(wr_valid), .wr_ready_in(wr_ready), .wr_addr_out(wr_addr),
		.wr_data_out(wr_data), .rd_addr_out(rd_addr), .rd_data_in(rd_data),
		.i2c_mode_out(i2c_mode), .busy_out(busy));
	regport_checker regport_checker_inst (.clk_in(clk_in), .rst_in(rst_in),
		.if_sel(lnk.if_sel), .cs_n(lnk.cs_n), .sclk(lnk.sclk), .dev_dat_out(lnk.dev_dat_out),
		.dev_dat_oe(lnk.dev_dat_oe), .dev_sdo_oe(lnk.dev_sdo_oe));
	assign rd_data = regs_r[rd_addr]; // combinational read, as the device expects
	always #5 clk_in = ~clk_in;
	// the register file takes a write at each handshake
	always @(posedge clk_in)
	begin
		if (wr_valid && wr_ready)
			regs_r[wr_addr] <= wr_data;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// one command: held until taken, then wait for the response pulse
	task automatic run_cmd(input logic wr, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge clk_in);
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_addr = a;
		cmd_data = d;
		while (cmd_ready !== 1'b1 && n < 2000)
		begin
			@(negedge clk_in);
			n++;
		end
		@(negedge clk_in);
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 4000)
		begin
			@(negedge clk_in);
			n++;
			busy_seen |= (busy === 1'b1);
		end
		check("response seen", {7'h00, rsp_valid}, 8'h01);
	endtask
	task automatic test_spi();
		run_cmd(1'b1, 5'h00, 8'hA5);
		run_cmd(1'b1, 5'h1F, 8'h5A);
		run_cmd(1'b0, 5'h00, 8'h00);
		check("spi read 00", rsp_data, 8'hA5);
		run_cmd(1'b0, 5'h1F, 8'h00);
		check("spi read 1F", rsp_data, 8'h5A);
		$display("test_spi done");
	endtask
	// stalled register file: two words held, the third frame is dropped
	task automatic test_buffer();
		int n;
		n = 0;
		wr_ready = 1'b0;
		run_cmd(1'b1, 5'h05, 8'h11);
		run_cmd(1'b1, 5'h06, 8'h22);
		run_cmd(1'b1, 5'h07, 8'h33);
		check("head valid", {7'h00, wr_valid}, 8'h01);
		check("head addr", {3'h0, wr_addr}, 8'h05);
		check("head data", wr_data, 8'h11);
		wr_ready = 1'b1;
		while (wr_valid !== 1'b0 && n < 20)
		begin
			@(negedge clk_in);
			n++;
		end
		check("reg 05", regs_r[5], 8'h11);
		check("reg 06", regs_r[6], 8'h22);
		check("reg 07", regs_r[7], 8'h00);
		$display("test_buffer done");
	endtask
	// the port type changes while idle and must be usable within the limit
	task automatic test_switch(input logic to_i2c);
		int n;
		n = 0;
		@(negedge clk_in);
		sel_i2c = to_i2c;
		@(negedge clk_in);
		while (cmd_ready !== 1'b1 && n < 2000)
		begin
			@(negedge clk_in);
			n++;
		end
		check("switch span", {7'h00, n <= SWITCH_MAX_NS / CLK_PERIOD_NS}, 8'h01);
		check("port type", {7'h00, i2c_mode}, {7'h00, to_i2c});
		$display("test_switch done");
	endtask
	task automatic test_i2c();
		busy_seen = 1'b0;
		run_cmd(1'b1, 5'h0A, 8'hC3);
		check("i2c write ack", {7'h00, rsp_ack}, 8'h01);
		check("reg 0A", regs_r[10], 8'hC3);
		run_cmd(1'b0, 5'h0A, 8'h00);
		check("i2c read 0A", rsp_data, 8'hC3);
		check("i2c read ack", {7'h00, rsp_ack}, 8'h01);
		run_cmd(1'b0, 5'h1F, 8'h00);
		check("i2c read 1F", rsp_data, 8'h5A);
		check("busy seen", {7'h00, busy_seen}, 8'h01);
		$display("test_i2c done");
	endtask
	// back on spi, a byte written over i2c reads the same
	task automatic test_spi_again();
		run_cmd(1'b0, 5'h0A, 8'h00);
		check("spi read 0A", rsp_data, 8'hC3);
		$display("test_spi_again done");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// the whole sequence needs about 7500 cycles; allow much more
	initial
	begin
		#1000000;
		num_errors++;
		conclude();
	end
	initial
	begin
		for (int i = 0; i < 32; i++)
			regs_r[i] = 8'h00;
		repeat (16) @(negedge clk_in);
		rst_in = 1'b0;
		test_spi();
		test_buffer();
		test_switch(1'b1);
		test_i2c();
		test_switch(1'b0);
		test_spi_again();
		conclude();
	end
endmodule
`default_nettype wire
